// [shared/si_params.svh]
// Register offsets, field positions and reset values of the integrity block
`ifndef SI_PARAMS_SVH
`define SI_PARAMS_SVH

// Byte offsets on the register bus
`define SI_OFS_CTRL_STATUS 12'h000
`define SI_OFS_IRQ_STATUS  12'h004
`define SI_OFS_IRQ_CLEAR   12'h008
`define SI_OFS_IRQ_ENABLE  12'h00c

// Fields of the control/status byte
`define SI_BIT_WDG_FLAG  4
`define SI_BIT_PLL_LOCK  3
`define SI_BIT_UV_FLAG   2
`define SI_BIT_WARN_FLAG 1
`define SI_BIT_WARN_IE   0

// Sticky interrupt status bits
`define SI_IRQ_W         2
`define SI_IRQ_WARN      0
`define SI_IRQ_LOCK_LOST 1

// Reset values
`define SI_CTRL_RESET   8'h00
`define SI_IRQ_EN_RESET 2'h0

`endif

// [shared/si_pkg.sv]
// Types shared by the integrity block
package si_pkg;

  // Tracker of the status-then-associated clearing sequence
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b01,
    SEQ_ARMED = 2'b10
  } clr_seq_t;

endpackage : si_pkg

// [src/sync2.sv]
// Two-stage synchroniser for asynchronous levels
`timescale 1ns/100ps
module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : sync2

// [src/sticky_bits.sv]
// Sticky event bits with hold; a set beats a clear in the same cycle
`timescale 1ns/100ps
module sticky_bits #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             hold,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  // State
  output logic      [WIDTH-1:0] q
);

  // Hold freezes the bits entirely
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (!hold) begin
      q <= set | (q & ~clr);
    end
  end

endmodule : sticky_bits

// [src/system_integrity_status.sv]
// Reset-cause flags, supply warning and its interrupt, behind an APB slave
`timescale 1ns/100ps
`include "si_params.svh"
module system_integrity_status (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog detector and PLL, asynchronous
  input  wire logic        supply_warn_cmp,
  input  wire logic        pll_lock_pin,
  // Configuration and reset manager, same clock
  input  wire logic        uv_detector_enable,
  input  wire logic        wdg_reset_cause,
  input  wire logic        uv_reset_cause,
  input  wire logic        retained_uv_flag,
  output logic             uv_flag_keep,
  // CPU core
  input  wire logic        global_irq_mask,
  input  wire logic        wait_mode,
  input  wire logic        halt_mode,
  input  wire logic        isr_entry_ack,
  output logic             supply_warn_irq_req,
  output logic             wake_from_wait,
  // Software interrupt line
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Synchronised pins and live flag views
  logic [1:0]             pin_sync;
  logic                   warn_level;
  logic                   lock_level;
  logic                   warn_flag_reg;
  logic                   lock_reg;
  logic                   warn_rise;
  logic                   lock_lost;
  logic                   live;

  // Reset-cause flags and enables
  logic                   boot_reg;
  logic                   uv_flag_reg;
  logic                   wdg_flag_reg;
  logic                   warn_ie_reg;
  logic [`SI_IRQ_W-1:0]   irq_en_reg;

  // Pending latches and the clearing sequence
  logic [`SI_IRQ_W-1:0]   pend;
  logic [`SI_IRQ_W-1:0]   pend_set;
  logic [`SI_IRQ_W-1:0]   pend_clr;
  logic                   warn_armed;
  si_pkg::clr_seq_t       seq_reg;
  si_pkg::clr_seq_t       seq_next;
  logic                   seq_clear;

  // Bus phase and address decode
  logic                   setup;
  logic                   access;
  logic                   wr;
  logic                   rd;
  logic                   hit_ctrl;
  logic                   hit_status;
  logic                   hit_clear;
  logic                   hit_enable;
  logic                   mapped;
  logic                   lane0;

  // Register strobes and write fields
  logic                   wr_ctrl;
  logic                   wr_enable;
  logic                   wr_clear;
  logic                   rd_ctrl;
  logic                   arm_status;
  logic                   wr_ie_bit;
  logic                   wr_wdg_bit;
  logic [`SI_IRQ_W-1:0]   wr_irq_bits;

  // Read path
  logic [7:0]             ctrl_view;
  logic [31:0]            rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  // Comparator and lock are both analog timing, so both get two stages
  sync2 #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({pll_lock_pin, supply_warn_cmp}),
    .q     (pin_sync)
  );

  // No new warning without the undervoltage detector; one already pending stays latched
  assign warn_level = pin_sync[0] & uv_detector_enable;

  // Lock view is not gated: the PLL runs without the detector
  assign lock_level = pin_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Live flags, frozen in Halt

  // Halt qualifier for the write and ctrl-read strobes below; flag views, sequence state and pending bits use halt_mode directly
  assign live = !halt_mode;

  // Flag views track the detector and the PLL lock except while halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_flag_reg <= 1'b0;
      lock_reg      <= 1'b0;
    end else if (!halt_mode) begin
      warn_flag_reg <= warn_level;
      lock_reg      <= lock_level;
    end
  end

  // A level that changed during Halt shows up as an edge on exit
  assign warn_rise = !halt_mode && warn_level && !warn_flag_reg;
  assign lock_lost = !halt_mode && !lock_level && lock_reg;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  assign setup      = psel && !penable;
  assign access     = psel && penable;
  assign wr         = access && pwrite;
  assign rd         = access && !pwrite;
  assign lane0      = pstrb[0];

  // Whole-word compare, so no aliases of the four registers
  assign hit_ctrl   = (paddr == `SI_OFS_CTRL_STATUS);
  assign hit_status = (paddr == `SI_OFS_IRQ_STATUS);
  assign hit_clear  = (paddr == `SI_OFS_IRQ_CLEAR);
  assign hit_enable = (paddr == `SI_OFS_IRQ_ENABLE);
  assign mapped     = hit_ctrl || hit_status || hit_clear || hit_enable;

  // Zero wait states; error only on an unmapped word
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Register strobes

  // Writes and read side effects, all dropped while halted
  assign wr_ctrl    = wr && hit_ctrl && lane0 && live;
  assign wr_enable  = wr && hit_enable && lane0 && live;
  assign wr_clear   = wr && hit_clear && lane0 && live;
  assign rd_ctrl    = rd && hit_ctrl && live;

  // A read or a write of the status word arms the sequence
  assign arm_status = access && hit_status;

  // Fields of the write word; reserved bits are never stored
  assign wr_ie_bit   = pwdata[`SI_BIT_WARN_IE];
  assign wr_wdg_bit  = pwdata[`SI_BIT_WDG_FLAG];
  assign wr_irq_bits = pwdata[`SI_IRQ_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Reset-cause flags

  // Causes are caught on the first edge after release, never under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end

  // Undervoltage flag: retained across other resets, cleared by a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_flag_reg <= 1'b0;
    end else if (boot_reg) begin
      uv_flag_reg <= uv_reset_cause || retained_uv_flag;
    end else if (rd_ctrl) begin
      uv_flag_reg <= 1'b0;
    end
  end

  // Watchdog flag: undervoltage reset forces it clear; software writes 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdg_flag_reg <= 1'b0;
    end else if (boot_reg) begin
      wdg_flag_reg <= wdg_reset_cause && !uv_reset_cause;
    end else if (wr_ctrl && !wr_wdg_bit) begin
      wdg_flag_reg <= 1'b0;
    end
  end

  // Value the always-on reset manager keeps for the next boot
  assign uv_flag_keep = uv_flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Enables

  // Software enable of the warning request; writes ignored while halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_ie_reg <= 1'(`SI_CTRL_RESET >> `SI_BIT_WARN_IE);
    end else if (wr_ctrl) begin
      warn_ie_reg <= wr_ie_bit;
    end
  end

  // Enable mask for the bus interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= `SI_IRQ_EN_RESET;
    end else if (wr_enable) begin
      irq_en_reg <= wr_irq_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clearing sequence

  // Status access with warning pending arms it; a ctrl access next fires it, any other non-status access disarms
  always_comb begin
    seq_next  = seq_reg;
    seq_clear = 1'b0;
    unique case (seq_reg)
      si_pkg::SEQ_IDLE: begin
        if (arm_status && pend[`SI_IRQ_WARN]) begin
          seq_next = si_pkg::SEQ_ARMED;
        end
      end
      si_pkg::SEQ_ARMED: begin
        if (access && hit_ctrl) begin
          seq_clear = 1'b1;
          seq_next  = si_pkg::SEQ_IDLE;
        end else if (access && !hit_status) begin
          seq_next = si_pkg::SEQ_IDLE;
        end
      end
      default: begin
        seq_next = si_pkg::SEQ_IDLE;
      end
    endcase
  end

  // Sequence state; halted accesses do not advance it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= si_pkg::SEQ_IDLE;
    end else if (!halt_mode) begin
      seq_reg <= seq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending latches

  // Latched whatever the enable or mask; only clears drop them
  assign pend_set = {lock_lost, warn_rise};

  // Write-1 clear, sequence clear and service entry
  always_comb begin
    pend_clr = '0;
    if (wr_clear) begin
      pend_clr = wr_irq_bits;
    end
    if (seq_clear || isr_entry_ack) begin
      pend_clr[`SI_IRQ_WARN] = 1'b1;
    end
  end

  // Two pending bits; halt freezes them with the register
  sticky_bits #(
    .WIDTH (`SI_IRQ_W)
  ) u_pend (
    .clk   (pclk),
    .rst_n (presetn),
    .hold  (halt_mode),
    .set   (pend_set),
    .clr   (pend_clr),
    .q     (pend)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt outputs

  // Enabled pending request, shared by the core and the wake path
  assign warn_armed = pend[`SI_IRQ_WARN] && warn_ie_reg;

  // Core sees the request only when enabled and unmasked
  assign supply_warn_irq_req = warn_armed
                               && !global_irq_mask;

  // Wait wakes on an enabled request; Halt never wakes from here
  assign wake_from_wait = wait_mode && !halt_mode
                          && warn_armed;

  // Bus-side line over the enable mask
  assign irq = |(pend & irq_en_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // Reserved top bits read as zero
  always_comb begin
    ctrl_view                    = 8'h00;
    ctrl_view[`SI_BIT_WDG_FLAG]  = wdg_flag_reg;
    ctrl_view[`SI_BIT_PLL_LOCK]  = lock_reg;
    ctrl_view[`SI_BIT_UV_FLAG]   = uv_flag_reg;
    ctrl_view[`SI_BIT_WARN_FLAG] = warn_flag_reg;
    ctrl_view[`SI_BIT_WARN_IE]   = warn_ie_reg;
  end

  // Clear register reads zero, unmapped reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[7:0] = ctrl_view;
    end else if (hit_status) begin
      rd_mux[`SI_IRQ_W-1:0] = pend;
    end else if (hit_enable) begin
      rd_mux[`SI_IRQ_W-1:0] = irq_en_reg;
    end
  end

  // Captured at setup so the access phase shows a stable word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule : system_integrity_status

// [verif/core_model.sv]
// Behavioural CPU core that enters the warning service routine
`timescale 1ns/100ps
module core_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bench control
  input  wire logic       serve_en,
  input  wire logic [1:0] delay,
  // Request and answer
  input  wire logic       supply_warn_irq_req,
  output logic            isr_entry_ack
);
  logic [1:0] wait_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Steady request for delay+1 cycles, then one entry pulse; a slow core waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt      <= 2'h0;
      isr_entry_ack <= 1'b0;
    end else if (serve_en && supply_warn_irq_req && !isr_entry_ack) begin
      wait_cnt      <= wait_cnt + 2'h1;
      isr_entry_ack <= (wait_cnt == delay);
    end else begin
      wait_cnt      <= 2'h0;
      isr_entry_ack <= 1'b0;
    end
  end
endmodule : core_model

// [verif/si_checker.sv]
// Port assertions of the integrity block
`timescale 1ns/100ps
module si_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  // Core and detector side
  input wire logic        supply_warn_cmp,
  input wire logic        uv_detector_enable,
  input wire logic        global_irq_mask,
  input wire logic        wait_mode,
  input wire logic        halt_mode,
  input wire logic        isr_entry_ack,
  input wire logic        uv_flag_keep,
  input wire logic        supply_warn_irq_req,
  input wire logic        wake_from_wait,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] cmp_h;

  ////////////////////////////////////////////////////////////////////////////////
  // Comparator history; a held level cannot raise a fresh event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cmp_h <= 4'h0;
    else
      cmp_h <= {cmp_h[2:0], supply_warn_cmp};
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_req_mask; supply_warn_irq_req |-> !global_irq_mask; endproperty
  a_req_mask: assert property (p_req_mask) else $error("request while masked");
  property p_wake; wake_from_wait |-> wait_mode && !halt_mode; endproperty
  a_wake: assert property (p_wake) else $error("wake outside wait");
  property p_halt;
    halt_mode && $past(halt_mode) && $past(presetn) |-> $stable(uv_flag_keep) && !wake_from_wait;
  endproperty
  a_halt: assert property (p_halt) else $error("state moved in halt");
  property p_rsvd; prdata[31:5] == 27'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_rdclr;
    psel && penable && !pwrite && paddr == 12'h000 && !halt_mode |=> !uv_flag_keep;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("flag kept after read");
  property p_ack;
    isr_entry_ack && !halt_mode && cmp_h == {4{supply_warn_cmp}} |=> !supply_warn_irq_req;
  endproperty
  a_ack: assert property (p_ack) else $error("request after entry");
  property p_rst; !$past(presetn) |-> !irq && !supply_warn_irq_req && !wake_from_wait; endproperty
  a_rst: assert property (p_rst) else $error("source live after reset");
  property p_nodet; !uv_detector_enable |-> !supply_warn_irq_req && !wake_from_wait; endproperty
  a_nodet: assert property (p_nodet) else $error("warning without detector");
endmodule : si_checker

bind system_integrity_status si_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .supply_warn_cmp, .uv_detector_enable, .global_irq_mask, .wait_mode,
  .halt_mode, .isr_entry_ack, .uv_flag_keep, .supply_warn_irq_req, .wake_from_wait, .irq);

// [verif/tb_system_integrity_status.sv]
// Directed APB bench of the integrity block with a core model
`timescale 1ns/100ps
module tb_system_integrity_status;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic        pready, pslverr, err, uv_flag_keep, isr_entry_ack, irq, wake_from_wait;
  logic        supply_warn_irq_req, supply_warn_cmp = 1'b0, pll_lock_pin = 1'b1;
  logic        uv_detector_enable = 1'b1, wdg_reset_cause = 1'b0, uv_reset_cause = 1'b0;
  logic        kept = 1'b0, global_irq_mask = 1'b1, wait_mode = 1'b0, halt_mode = 1'b0;
  logic        serve = 1'b0;
  int          num_errors = 0, checks_done = 0, cycles = 0;

  system_integrity_status u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .supply_warn_cmp, .pll_lock_pin,
    .uv_detector_enable, .wdg_reset_cause, .uv_reset_cause, .retained_uv_flag(kept),
    .uv_flag_keep, .global_irq_mask, .wait_mode, .halt_mode, .isr_entry_ack,
    .supply_warn_irq_req, .wake_from_wait, .irq);
  core_model u_core (.pclk, .presetn, .serve_en(serve), .delay(2'h2), .supply_warn_irq_req,
    .isr_entry_ack);

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, always-on copy of the flag, and a hang limit far above the run
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (presetn) kept <= uv_flag_keep;
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out;
    $display("Errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk

  // One transfer, then an idle edge so no signal is driven twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(d, e);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  task automatic do_reset(input logic w, input logic u);
    presetn <= 1'b0;
    wdg_reset_cause <= w;
    uv_reset_cause <= u;
    tick(20);
    presetn <= 1'b1;
    tick(2);
    wdg_reset_cause <= 1'b0;
    uv_reset_cause <= 1'b0;
    // Lock and warning views need three edges after release
    tick(2);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'b0, 1'b0);
    rd(12'h000, 32'h08);
    rd(12'h00c, 32'h0);
    rd(12'h010, 32'h0);
    chk(32'(err), 32'h1);
    chk(32'(pready), 32'h1);
    do_reset(1'b1, 1'b0);
    rd(12'h000, 32'h18);
    do_reset(1'b1, 1'b1);
    rd(12'h000, 32'h0c);
    do_reset(1'b0, 1'b1);
    do_reset(1'b1, 1'b0);
    rd(12'h000, 32'h1c);
    rd(12'h000, 32'h18);
    apb(1'b1, 12'h000, 32'h0);
    rd(12'h000, 32'h08);
    pll_lock_pin <= 1'b0;
    tick(4);
    rd(12'h000, 32'h00);
    rd(12'h004, 32'h2);
    apb(1'b1, 12'h008, 32'h2);
    rd(12'h004, 32'h0);
    pll_lock_pin <= 1'b1;
    apb(1'b1, 12'h00c, 32'h1);
    apb(1'b1, 12'h000, 32'h1);
    rd(12'h00c, 32'h1);
    supply_warn_cmp <= 1'b1;
    tick(4);
    rd(12'h000, 32'h0b);
    chk(32'(supply_warn_irq_req), 32'h0);
    rd(12'h004, 32'h1);
    chk(32'(irq), 32'h1);
    wait_mode <= 1'b1;
    tick(1);
    chk(32'(wake_from_wait), 32'h1);
    wait_mode <= 1'b0;
    serve <= 1'b1;
    global_irq_mask <= 1'b0;
    tick(8);
    chk(32'(supply_warn_irq_req), 32'h0);
    rd(12'h004, 32'h0);
    // Fresh event, masked, then the status-then-associated clear
    serve <= 1'b0;
    global_irq_mask <= 1'b1;
    supply_warn_cmp <= 1'b0;
    tick(4);
    supply_warn_cmp <= 1'b1;
    tick(4);
    rd(12'h004, 32'h1);
    rd(12'h000, 32'h0b);
    chk(32'(irq), 32'h0);
    global_irq_mask <= 1'b0;
    tick(2);
    chk(32'(supply_warn_irq_req), 32'h0);
    global_irq_mask <= 1'b1;
    supply_warn_cmp <= 1'b0;
    tick(4);
    supply_warn_cmp <= 1'b1;
    tick(4);
    chk(32'(irq), 32'h1);
    apb(1'b1, 12'h008, 32'h1);
    chk(32'(irq), 32'h0);
    // Halt freezes writes and pending state
    halt_mode <= 1'b1;
    apb(1'b1, 12'h000, 32'h0);
    supply_warn_cmp <= 1'b0;
    tick(4);
    supply_warn_cmp <= 1'b1;
    tick(4);
    rd(12'h004, 32'h0);
    halt_mode <= 1'b0;
    tick(1);
    rd(12'h000, 32'h0b);
    // Detector off: no flag and no pending event
    apb(1'b1, 12'h000, 32'h0);
    supply_warn_cmp <= 1'b0;
    tick(4);
    apb(1'b1, 12'h008, 32'h1);
    uv_detector_enable <= 1'b0;
    supply_warn_cmp <= 1'b1;
    tick(4);
    rd(12'h000, 32'h08);
    rd(12'h004, 32'h0);
    close_out();
  end
endmodule : tb_system_integrity_status
